// ---- hdl/ccc_chain_ctrl.sv ----
/*
 Channel command chaining controller: fetches entries, checks them,
 starts operations on the I/O unit and chains data and commands.
 Assumes storage answers each fetch request exactly once, and the
 I/O unit reports area exhaustion and operation end as pulses.
*/
`timescale 1ns/1ps
// Overview of operation
// - data chain flag fetches next area entry
// - command chain flag starts next command
// - length suppress hides incorrect length when not data chaining
// - both flags chain despite incorrect length when no interruption pending
// - immediate operations ignore incorrect length
// - skip flag blocks storing input data
// - progress flag requests interruption when enabled
// - low sixteen bits are byte count
// - nonzero reserved bits give program check
// - program check handled per chaining context
// - command class from low order bits
// - invalid code checked only when starting
// - check parity, ignore high command bits
// - full command byte goes to unit
// - nonexistent storage reference gives program check
// - zero count gives program check
// - prefetch errors reported only when used
// - entries ascend by doubleword, same unit
// - flags carried through branch entries
// - faults end chain and raise interruption
// - status modifier chains sixteen bytes higher
// - command code in top byte
// - data address in next three bytes
module ccc_chain_ctrl (
	input wire logic clk,
	input wire logic reset,
	input wire logic startIo,
	input wire logic [ccc_pkg::ADDR_W-1:0] startPtr,
	input wire logic [ccc_pkg::UNIT_W-1:0] startUnit,
	input wire logic channelEnabled,
	input wire logic intPending,
	output logic fetchReq,
	output logic [ccc_pkg::ADDR_W-1:0] fetchAddr,
	input wire logic entryValid,
	input wire logic [ccc_pkg::ENTRY_W-1:0] entryWord,
	input wire logic entryParity,
	input wire logic entryBad,
	output logic opStart,
	output logic opNewArea,
	output logic opTerminate,
	output logic [ccc_pkg::CMD_W-1:0] opCmd,
	output logic [ccc_pkg::UNIT_W-1:0] opUnit,
	output logic [ccc_pkg::ADDR_W-1:0] opAddr,
	output logic [ccc_pkg::CNT_W-1:0] opCount,
	output logic opSkip,
	output logic opBackward,
	output logic opOutput,
	input wire logic areaDone,
	input wire logic unitEnd,
	input wire ccc_pkg::ccc_unit_end_s unitEndSt,
	input wire logic dataBad,
	output logic progressReq,
	output logic doneValid,
	output ccc_pkg::ccc_done_s doneSt,
	output logic busy
);
	import ccc_pkg::*;

	// state and context
	ccc_state_e state_q, state_d;
	ccc_ctx_e ctx_q; // how the entry in hand was reached
	ccc_flags_s flags_q; // flags of the running entry
	logic [ADDR_W-1:0] curAddr_q; // address of the entry in hand
	logic [ENTRY_W-1:0] ent_q; // entry in hand
	logic entPar_q; // its command parity bit
	logic entBad_q; // its fetch hit missing storage
	logic entHave_q; // a prefetched entry waits in ent_q
	logic pfIssued_q; // one prefetch per entry
	logic ticLast_q; // previous entry was a branch
	logic pgmPend_q; // program check held for the ending
	logic progPend_q; // progress interruption not yet taken
	// output registers
	logic fetchReq_q, opStart_q, opNewArea_q, opTerminate_q;
	logic [ADDR_W-1:0] fetchAddr_q, opAddr_q;
	logic [CMD_W-1:0] opCmd_q;
	logic [UNIT_W-1:0] opUnit_q;
	logic [CNT_W-1:0] opCount_q;
	logic opSkip_q, opBackward_q, opOutput_q;
	logic progressReq_q, doneValid_q, busy_q;
	ccc_done_s doneSt_q;

	// decode of the entry in hand
	ccc_fields_s fields;
	ccc_class_e cls;
	logic resvBad, zeroCount, cmdBad;
	ccc_entry_decode uDecode (
		.entryWord(ent_q),
		.cmdParity(entPar_q),
		.fields(fields),
		.cls(cls),
		.resvBad(resvBad),
		.zeroCount(zeroCount),
		.cmdBad(cmdBad)
	);

	// ending judgement for the running operation
	logic lenReport, chainGo;
	logic [ADDR_W-1:0] nextAddr;
	ccc_end_judge uJudge (
		.flags(flags_q),
		.endSt(unitEndSt),
		.intPending(intPending),
		.curAddr(curAddr_q),
		.lenReport(lenReport),
		.chainGo(chainGo),
		.nextAddr(nextAddr)
	);

	// decoding of events
	logic inIdle, inCheck, inRun, inDrain, isTic, isInput, dcCtx;
	logic fetchDone, chkErr, goTic, goStart, goArea;
	logic failStart, failData, endNow, chainNow, finishNow;
	logic areaNow, pfWant, dataBadNow, useHeld, skipNew;
	logic [ADDR_W-1:0] seqAddr;
	ccc_done_s endDone, failDone;
	assign inIdle = state_q == CCC_IDLE;
	assign inCheck = state_q == CCC_CHECK;
	assign inRun = state_q == CCC_RUN;
	assign inDrain = state_q == CCC_DRAIN;
	assign isTic = cls == CCC_BRANCH;
	assign isInput = (cls == CCC_IN_FWD) | (cls == CCC_IN_BWD);
	assign dcCtx = ctx_q == CCC_DCHAIN;
	assign fetchDone = fetchReq_q & entryValid;
	assign seqAddr = curAddr_q + ENTRY_STEP;
	// code checks skipped for data chained entries
	assign chkErr = entBad_q | (isTic & ticLast_q) |
		(~isTic & (resvBad | zeroCount | (~dcCtx & cmdBad)));
	assign goTic = inCheck & isTic & ~chkErr;
	assign goStart = inCheck & ~isTic & ~dcCtx & ~chkErr;
	assign goArea = inCheck & ~isTic & dcCtx & ~chkErr;
	// program check placement
	assign failStart = inCheck & chkErr & ~dcCtx;
	assign failData = inCheck & chkErr & dcCtx;
	assign endNow = inRun & unitEnd;
	assign chainNow = endNow & chainGo;
	assign finishNow = endNow & ~chainGo;
	// a terminated operation asks for no further area
	assign areaNow = inRun & areaDone & flags_q.dataChain & ~pgmPend_q &
		~unitEnd;
	// prefetch only during output data chaining
	assign pfWant = inRun & opOutput_q & flags_q.dataChain & ~pfIssued_q &
		~fetchReq_q & ~unitEnd & ~areaNow;
	assign dataBadNow = inRun & dataBad & ~unitEnd;
	assign useHeld = entHave_q | fetchDone;
	// skip is meaningful only for input operations
	assign skipNew = fields.flags.skip & (goArea ? ~opOutput_q : isInput);
	assign endDone = '{atStart: 1'b0, programCheck: pgmPend_q,
		lengthWrong: lenReport, dataCheck: unitEndSt.dataCheck,
		exceptional: unitEndSt.exceptional,
		deviceEnd: unitEndSt.deviceEnd, statusMod: unitEndSt.statusMod,
		progress: progPend_q};
	// first entry stores at start, chained one interrupts
	assign failDone = '{atStart: ctx_q == CCC_FIRST, programCheck: 1'b1,
		lengthWrong: 1'b0, dataCheck: 1'b0, exceptional: 1'b0,
		deviceEnd: 1'b0, statusMod: 1'b0, progress: progPend_q};

	// next state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			CCC_IDLE: begin
				if (startIo) state_d = CCC_FETCH;
			end
			CCC_FETCH: begin
				if (entryValid) state_d = CCC_CHECK;
			end
			CCC_CHECK: begin
				// branch refetches, failed start ends at once
				if (goTic) state_d = CCC_FETCH;
				else if (failStart) state_d = CCC_IDLE;
				else state_d = CCC_RUN;
			end
			CCC_RUN: begin
				if (chainNow) state_d = CCC_FETCH;
				else if (finishNow) begin
					// an unanswered prefetch must be swallowed
					state_d = (fetchReq_q & ~entryValid) ? CCC_DRAIN : CCC_IDLE;
				end else if (areaNow) begin
					state_d = useHeld ? CCC_CHECK : CCC_FETCH;
				end
			end
			CCC_DRAIN: begin
				if (entryValid) state_d = CCC_IDLE;
			end
			default: state_d = CCC_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) state_q <= CCC_IDLE;
		else state_q <= state_d;
	end

	// chaining context
	always_ff @(posedge clk or posedge reset) begin
		if (reset) ctx_q <= CCC_FIRST;
		else if (inIdle & startIo) ctx_q <= CCC_FIRST;
		else if (chainNow) ctx_q <= CCC_CCHAIN;
		else if (areaNow) ctx_q <= CCC_DCHAIN;
	end

	// storage request, held until answered
	always_ff @(posedge clk or posedge reset) begin
		if (reset) fetchReq_q <= 1'b0;
		else if (fetchDone) fetchReq_q <= 1'b0;
		else if ((inIdle & startIo) | goTic | chainNow | pfWant) begin
			fetchReq_q <= 1'b1;
		end else if (areaNow & ~useHeld) fetchReq_q <= 1'b1;
	end

	// request address
	always_ff @(posedge clk or posedge reset) begin
		if (reset) fetchAddr_q <= '0;
		else if (inIdle & startIo) fetchAddr_q <= startPtr;
		else if (goTic) fetchAddr_q <= fields.addr;
		else if (chainNow) fetchAddr_q <= nextAddr;
		else if (pfWant | (areaNow & ~fetchReq_q)) fetchAddr_q <= seqAddr;
	end

	// entry capture; answers during drain are thrown away
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ent_q <= '0;
			entPar_q <= 1'b0;
			entBad_q <= 1'b0;
			curAddr_q <= '0;
		end else if (fetchDone & ~inDrain) begin
			ent_q <= entryWord;
			entPar_q <= entryParity;
			entBad_q <= entryBad;
			curAddr_q <= fetchAddr_q;
		end
	end

	// held prefetch; its faults wait in ent_q until used
	always_ff @(posedge clk or posedge reset) begin
		if (reset) entHave_q <= 1'b0;
		else if (inCheck | inIdle) entHave_q <= 1'b0;
		else if (fetchDone & inRun) entHave_q <= 1'b1;
	end

	// one prefetch per running entry
	always_ff @(posedge clk or posedge reset) begin
		if (reset) pfIssued_q <= 1'b0;
		else if (pfWant) pfIssued_q <= 1'b1;
		else if (goStart | goArea | inIdle) pfIssued_q <= 1'b0;
	end

	// running flags; a branch keeps the previous ones
	always_ff @(posedge clk or posedge reset) begin
		if (reset) flags_q <= '0;
		else if (inIdle) flags_q <= '0;
		else if (goStart | goArea) flags_q <= fields.flags;
	end

	// two branches in a row are refused
	always_ff @(posedge clk or posedge reset) begin
		if (reset) ticLast_q <= 1'b0;
		else if (goTic) ticLast_q <= 1'b1;
		else if (inCheck | inIdle) ticLast_q <= 1'b0;
	end

	// program check found mid operation, reported at the end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) pgmPend_q <= 1'b0;
		else if (failData | dataBadNow) pgmPend_q <= 1'b1;
		else if (inIdle) pgmPend_q <= 1'b0;
	end

	// progress interruption, not stacked; a new flag wins over clear
	always_ff @(posedge clk or posedge reset) begin
		if (reset) progPend_q <= 1'b0;
		else if ((goStart | goArea) & fields.flags.progress) begin
			progPend_q <= 1'b1;
		end else if (progressReq_q | finishNow | failStart) begin
			progPend_q <= 1'b0;
		end
	end

	// progress request once the channel is enabled, no interruption is pending and an operation runs
	always_ff @(posedge clk or posedge reset) begin
		if (reset) progressReq_q <= 1'b0;
		else progressReq_q <= progPend_q & channelEnabled & ~intPending &
			~progressReq_q & inRun;
	end

	// operation strobes towards the I/O unit
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			opStart_q <= 1'b0;
			opNewArea_q <= 1'b0;
			opTerminate_q <= 1'b0;
		end else begin
			opStart_q <= goStart;
			opNewArea_q <= goArea;
			// the unit is told to stop
			opTerminate_q <= failData | dataBadNow;
		end
	end

	// unit named at start serves the whole chain
	always_ff @(posedge clk or posedge reset) begin
		if (reset) opUnit_q <= '0;
		else if (inIdle & startIo) opUnit_q <= startUnit;
	end

	// command byte and direction, loaded only when a command starts
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			opCmd_q <= '0;
			opBackward_q <= 1'b0;
			opOutput_q <= 1'b0;
		end else if (goStart) begin
			opCmd_q <= fields.cmd;
			opBackward_q <= cls == CCC_IN_BWD;
			opOutput_q <= cls == CCC_OUT_FWD;
		end
	end

	// storage area and skip, renewed by data chaining
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			opAddr_q <= '0;
			opCount_q <= '0;
			opSkip_q <= 1'b0;
		end else if (goStart | goArea) begin
			opAddr_q <= fields.addr;
			opCount_q <= fields.count;
			opSkip_q <= skipNew;
		end
	end

	// completion status, one pulse per ended chain
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			doneValid_q <= 1'b0;
			doneSt_q <= '0;
		end else begin
			doneValid_q <= failStart | finishNow;
			if (failStart) doneSt_q <= failDone;
			else if (finishNow) doneSt_q <= endDone;
		end
	end

	// busy while any part of a chain is alive
	always_ff @(posedge clk or posedge reset) begin
		if (reset) busy_q <= 1'b0;
		else busy_q <= state_d != CCC_IDLE;
	end

	// ports straight from registers
	assign fetchReq = fetchReq_q;
	assign fetchAddr = fetchAddr_q;
	assign opStart = opStart_q;
	assign opNewArea = opNewArea_q;
	assign opTerminate = opTerminate_q;
	assign opCmd = opCmd_q;
	assign opUnit = opUnit_q;
	assign opAddr = opAddr_q;
	assign opCount = opCount_q;
	assign opSkip = opSkip_q;
	assign opBackward = opBackward_q;
	assign opOutput = opOutput_q;
	assign progressReq = progressReq_q;
	assign doneValid = doneValid_q;
	assign doneSt = doneSt_q;
	assign busy = busy_q;

	// checks on the block's own behaviour
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	AST_AREA_FETCH: assert property (
		areaNow |=> (fetchReq_q || inCheck) && ctx_q == CCC_DCHAIN)
		else $error("data chaining did not fetch the next entry");
	AST_CHAIN_NEXT: assert property (
		chainNow |=> fetchReq_q && fetchAddr_q == $past(nextAddr))
		else $error("command chaining fetched the wrong address");
	AST_LEN_SUPPRESS: assert property (
		finishNow && flags_q.lenSup && !flags_q.dataChain
		|=> doneValid_q && !doneSt_q.lengthWrong)
		else $error("suppressed length fault was reported");
	AST_LEN_CHAIN: assert property (
		endNow && flags_q.cmdChain && flags_q.lenSup && !flags_q.dataChain
		&& !intPending && unitEndSt.deviceEnd && !unitEndSt.dataCheck
		&& !unitEndSt.exceptional |-> chainNow)
		else $error("length fault stopped chaining despite both flags");
	AST_IMMEDIATE: assert property (
		finishNow && unitEndSt.immediate |=> !doneSt_q.lengthWrong)
		else $error("length fault reported on an immediate operation");
	AST_FAULT_ENDS: assert property (
		endNow && (unitEndSt.dataCheck || unitEndSt.exceptional)
		|=> doneValid_q ##1 !busy_q || fetchReq_q)
		else $error("faulted operation did not end the chain");
	AST_SKIP_INPUT: assert property (
		opStart_q && opOutput_q |-> !opSkip_q)
		else $error("skip set on an output operation");
	AST_RESV_CHECK: assert property (
		inCheck && resvBad && !dcCtx |=> doneValid_q
		&& doneSt_q.programCheck && !opStart_q)
		else $error("reserved bits did not give a program check");
	AST_ZERO_TERM: assert property (
		inCheck && dcCtx && zeroCount |=> opTerminate_q && !opNewArea_q)
		else $error("zero count while data chaining not terminated");
	AST_CODE_IGNORED: assert property (
		inCheck && dcCtx && cmdBad && !resvBad && !zeroCount && !isTic
		&& !entBad_q |=> opNewArea_q && !opTerminate_q)
		else $error("command code checked during data chaining");
	AST_FULL_CMD: assert property (
		goStart |=> opStart_q && opCmd_q == $past(fields.cmd))
		else $error("command byte not passed whole to the unit");
	AST_PROGRESS: assert property (
		progPend_q && channelEnabled && !intPending && inRun
		&& !progressReq_q |=> progressReq_q)
		else $error("progress request not raised when enabled");

	COV_CMD_CHAIN: cover property (chainNow ##[1:20] opStart_q);
	COV_AREA: cover property (areaNow ##[1:20] opNewArea_q);
	COV_SKIP_AHEAD: cover property (chainNow && unitEndSt.statusMod);
	COV_FAIL_START: cover property (failStart && ctx_q == CCC_FIRST);
endmodule

// ---- hdl/ccc_pkg.sv ----
/*
 Shared constants and types for the channel command chaining block.
 Assumes entry bit 0 is the most significant bit of the 64-bit word.
*/
package ccc_pkg;
	// entry geometry
	localparam int ENTRY_W = 64;
	localparam int ADDR_W = 24;
	localparam int CNT_W = 16;
	localparam int CMD_W = 8;
	localparam int RESV_W = 3;
	localparam int UNIT_W = 8;
	// field positions, counted from the most significant bit
	localparam int CMD_POS = 0;
	localparam int ADDR_POS = 8;
	localparam int DCF_POS = 32;
	localparam int CCF_POS = 33;
	localparam int LSF_POS = 34;
	localparam int SKIP_POS = 35;
	localparam int PROG_POS = 36;
	localparam int RESV_POS = 37;
	localparam int CNT_POS = 48;
	// address steps between entries
	localparam logic [ADDR_W-1:0] ENTRY_STEP = 24'h00_0008;
	localparam logic [ADDR_W-1:0] SKIP_STEP = 24'h00_0010;
	// low-order command patterns
	localparam logic [1:0] CMD_WRITE2 = 2'h1;
	localparam logic [1:0] CMD_READ2 = 2'h2;
	localparam logic [1:0] CMD_CTRL2 = 2'h3;
	localparam logic [3:0] CMD_SENSE4 = 4'h4;
	localparam logic [3:0] CMD_RDBK4 = 4'hc;
	localparam logic [3:0] CMD_TIC4 = 4'h8;

	typedef enum logic [2:0] {
		CCC_OUT_FWD, CCC_IN_FWD, CCC_IN_BWD, CCC_BRANCH, CCC_INVALID
	} ccc_class_e;

	// gray codes along idle, fetch, check, run
	typedef enum logic [2:0] {
		CCC_IDLE = 3'h0, CCC_FETCH = 3'h1, CCC_CHECK = 3'h3,
		CCC_RUN = 3'h2, CCC_DRAIN = 3'h6
	} ccc_state_e;

	typedef enum logic [1:0] {
		CCC_FIRST, CCC_DCHAIN, CCC_CCHAIN
	} ccc_ctx_e;

	typedef struct packed {
		logic dataChain;
		logic cmdChain;
		logic lenSup;
		logic skip;
		logic progress;
	} ccc_flags_s;

	typedef struct packed {
		logic [CMD_W-1:0] cmd;
		logic [ADDR_W-1:0] addr;
		ccc_flags_s flags;
		logic [CNT_W-1:0] count;
	} ccc_fields_s;

	// ending status offered by the I/O unit
	typedef struct packed {
		logic deviceEnd;
		logic statusMod;
		logic dataCheck;
		logic exceptional;
		logic lengthWrong;
		logic immediate;
	} ccc_unit_end_s;

	// completion status towards the processor side
	typedef struct packed {
		logic atStart;
		logic programCheck;
		logic lengthWrong;
		logic dataCheck;
		logic exceptional;
		logic deviceEnd;
		logic statusMod;
		logic progress;
	} ccc_done_s;
endpackage

// ---- hdl/ccc_entry_decode.sv ----
/*
 Field extraction and command classification of one fetched entry.
 Purely combinational; the caller holds the entry in a register.
*/
`timescale 1ns/1ps
module ccc_entry_decode (
	input wire logic [ccc_pkg::ENTRY_W-1:0] entryWord,
	input wire logic cmdParity,
	output ccc_pkg::ccc_fields_s fields,
	output ccc_pkg::ccc_class_e cls,
	output logic resvBad,
	output logic zeroCount,
	output logic cmdBad
);
	import ccc_pkg::*;
	localparam int TOP = ENTRY_W - 1;
	logic [1:0] low2; // class bits
	logic [3:0] low4; // class bits when low2 is zero
	logic [RESV_W-1:0] resv; // must be zero
	// field slicing
	assign fields.cmd = entryWord[TOP-CMD_POS -: CMD_W];
	assign fields.addr = entryWord[TOP-ADDR_POS -: ADDR_W];
	assign fields.flags.dataChain = entryWord[TOP-DCF_POS];
	assign fields.flags.cmdChain = entryWord[TOP-CCF_POS];
	assign fields.flags.lenSup = entryWord[TOP-LSF_POS];
	assign fields.flags.skip = entryWord[TOP-SKIP_POS];
	assign fields.flags.progress = entryWord[TOP-PROG_POS];
	assign fields.count = entryWord[TOP-CNT_POS -: CNT_W];
	assign resv = entryWord[TOP-RESV_POS -: RESV_W];
	// high-order bits play no part in the class
	assign low2 = fields.cmd[1:0];
	assign low4 = fields.cmd[3:0];
	// classification
	assign cls = (low2 == CMD_WRITE2 || low2 == CMD_CTRL2) ? CCC_OUT_FWD :
		(low2 == CMD_READ2) ? CCC_IN_FWD :
		(low4 == CMD_SENSE4) ? CCC_IN_FWD :
		(low4 == CMD_RDBK4) ? CCC_IN_BWD :
		(low4 == CMD_TIC4) ? CCC_BRANCH : CCC_INVALID;
	// odd parity over the byte
	assign cmdBad = ~(^{fields.cmd, cmdParity}) | (cls == CCC_INVALID);
	// branch entries are exempt from these checks
	assign resvBad = (|resv) & (cls != CCC_BRANCH);
	assign zeroCount = (fields.count == '0) & (cls != CCC_BRANCH);
endmodule

// ---- hdl/ccc_end_judge.sv ----
/*
 Decides at the end of an operation whether to chain and where to.
 Combinational; flags belong to the entry that ran the operation.
*/
`timescale 1ns/1ps
module ccc_end_judge (
	input wire ccc_pkg::ccc_flags_s flags,
	input wire ccc_pkg::ccc_unit_end_s endSt,
	input wire logic intPending,
	input wire logic [ccc_pkg::ADDR_W-1:0] curAddr,
	output logic lenReport,
	output logic chainGo,
	output logic [ccc_pkg::ADDR_W-1:0] nextAddr
);
	import ccc_pkg::*;
	logic lenSeen; // length fault that counts at all
	logic lenBlock; // length fault that stops chaining
	// immediate operations never show length faults
	assign lenSeen = endSt.lengthWrong & ~endSt.immediate;
	// suppression only when data chaining is off
	assign lenReport = lenSeen & ~(flags.lenSup & ~flags.dataChain);
	// both flags and a quiet channel let chaining proceed
	assign lenBlock = lenSeen & ~(flags.cmdChain & flags.lenSup & ~intPending);
	// data chain flag overrides command chain flag
	assign chainGo = flags.cmdChain & ~flags.dataChain & endSt.deviceEnd &
		~endSt.dataCheck & ~endSt.exceptional & ~lenBlock;
	// status modifier skips one entry
	assign nextAddr = curAddr +
		((endSt.statusMod & endSt.deviceEnd) ? SKIP_STEP : ENTRY_STEP);
endmodule

// ---- tb/ccc_far_model.sv ----
/*
 Far side of the chaining controller: storage that answers entry fetches
 and an I/O unit that ends each started operation with a set status.
 Assumes the bench fills the entry store before each start.
*/
`timescale 1ns/1ps
module ccc_far_model (
	input wire logic clk,
	input wire logic fetchReq,
	input wire logic [ccc_pkg::ADDR_W-1:0] fetchAddr,
	input wire logic opStart,
	input wire logic opNewArea,
	input wire ccc_pkg::ccc_unit_end_s endCfg,
	output logic entryValid,
	output logic [ccc_pkg::ENTRY_W-1:0] entryWord,
	output logic entryParity,
	output logic entryBad,
	output logic unitEnd,
	output ccc_pkg::ccc_unit_end_s unitEndSt
);
	import ccc_pkg::*;
	logic [ENTRY_W-1:0] mem [0:15]; // sixteen doublewords from address 0
	logic slow_q = 1'b0; // alternates prompt and slow answers
	int cnt = 0;
	int uCnt = 0;
	initial begin
		entryValid = 1'b0;
		entryWord = '0;
		entryParity = 1'b0;
		entryBad = 1'b0;
		unitEnd = 1'b0;
		unitEndSt = '0;
	end
	// storage and unit both move on the falling edge
	always @(negedge clk) begin
		entryValid <= 1'b0;
		entryBad <= 1'b0;
		// released bus must not keep showing the last entry
		entryWord <= ~entryWord;
		unitEnd <= 1'b0;
		unitEndSt <= ~endCfg;
		if (fetchReq === 1'b1 && !entryValid) begin
			if (cnt >= (slow_q ? 3 : 0)) begin
				cnt <= 0;
				slow_q <= ~slow_q;
				entryValid <= 1'b1;
				entryWord <= mem[fetchAddr[6:3]];
				entryParity <= ~^mem[fetchAddr[6:3]][63:56];
				entryBad <= |fetchAddr[23:7];
			end else begin
				cnt <= cnt + 1;
			end
		end
		// unit ends four cycles after a start or a new area,
		// and waits while an entry fetch is outstanding
		if (opStart === 1'b1 || opNewArea === 1'b1) begin
			uCnt <= 4;
		end else if (fetchReq === 1'b1) begin
			uCnt <= uCnt;
		end else if (uCnt == 1) begin
			unitEnd <= 1'b1;
			unitEndSt <= endCfg;
			uCnt <= 0;
		end else if (uCnt > 1) begin
			uCnt <= uCnt - 1;
		end
	end
endmodule

// ---- tb/testbench.sv ----
/*
 Self-checking bench: starts short channel programs and compares
 the started commands and the ending status with expectations.
 Assumes the far-side model ends every operation it sees start.
*/
`timescale 1ns/1ps
module testbench;
	import ccc_pkg::*;
	logic clk = 0, reset = 1, startIo = 0, channelEnabled = 0;
	logic fetchReq, entryValid, entryParity, entryBad, opStart, opNewArea;
	logic opTerminate, opSkip, opBackward, opOutput, unitEnd;
	logic progressReq, doneValid, busy;
	logic [ADDR_W-1:0] startPtr = '0, fetchAddr, opAddr;
	logic [UNIT_W-1:0] startUnit = '0, opUnit;
	logic [CMD_W-1:0] opCmd, lastCmd;
	logic [CNT_W-1:0] opCount, lastCnt, cnt;
	logic [ENTRY_W-1:0] entryWord;
	ccc_unit_end_s endCfg = '0, unitEndSt;
	ccc_done_s doneSt;
	logic intPending = 0, areaDone = 0, dataBad = 0;
	logic [1:0] inj = '0; // bit 0: area ends, bit 1: data fault
	int areas = 0, progs = 0, terms = 0;
	int seed = 54054, fail_count = 0, n_compared = 0, ops = 0, cyc = 0;
	always #2.5 clk = ~clk;
	ccc_chain_ctrl dut_u (.clk(clk), .reset(reset), .startIo(startIo),
		.startPtr(startPtr), .startUnit(startUnit),
		.channelEnabled(channelEnabled), .intPending(intPending),
		.fetchReq(fetchReq), .fetchAddr(fetchAddr), .entryValid(entryValid),
		.entryWord(entryWord), .entryParity(entryParity),
		.entryBad(entryBad), .opStart(opStart), .opNewArea(opNewArea),
		.opTerminate(opTerminate), .opCmd(opCmd), .opUnit(opUnit),
		.opAddr(opAddr), .opCount(opCount), .opSkip(opSkip),
		.opBackward(opBackward), .opOutput(opOutput), .areaDone(areaDone),
		.unitEnd(unitEnd), .unitEndSt(unitEndSt), .dataBad(dataBad),
		.progressReq(progressReq), .doneValid(doneValid), .doneSt(doneSt),
		.busy(busy));
	ccc_far_model far_u (.clk(clk), .fetchReq(fetchReq),
		.fetchAddr(fetchAddr), .opStart(opStart), .opNewArea(opNewArea),
		.endCfg(endCfg), .entryValid(entryValid), .entryWord(entryWord),
		.entryParity(entryParity), .entryBad(entryBad), .unitEnd(unitEnd),
		.unitEndSt(unitEndSt));
	// capture started commands, count strobes, inject unit events
	always @(negedge clk) begin
		areaDone = inj[0] && opStart === 1'b1;
		dataBad = inj[1] && opStart === 1'b1;
		if (opNewArea === 1'b1) areas++;
		if (progressReq === 1'b1) progs++;
		if (opTerminate === 1'b1) terms++;
		if (opStart === 1'b1) begin
			ops++;
			lastCmd = opCmd;
			lastCnt = opCount;
		end
	end
	// hang guard, far above the expected run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			give_verdict();
		end
	end
	// entry: command, data address 0x40, flags, reserved bits, count
	function automatic logic [63:0] mk(input logic [7:0] c,
		input logic [4:0] f, input logic [2:0] r, input logic [15:0] n);
		return {c, 24'h00_0040, f, r, 8'h00, n};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one channel program from ptr; checks status, op count, last command
	task automatic run(input logic [23:0] ptr, input logic [5:0] ec,
		input logic [7:0] mask, input logic [7:0] expD, input int expOps,
		input logic [7:0] expCmd);
		int i;
		endCfg = ec;
		ops = 0;
		areas = 0;
		progs = 0;
		terms = 0;
		startUnit = 8'($random(seed));
		channelEnabled = 1'($random(seed));
		startIo = 1'b1;
		startPtr = ptr;
		@(negedge clk);
		startIo = 1'b0;
		i = 0;
		while (doneValid !== 1'b1 && i < 300) begin
			@(negedge clk);
			i++;
		end
		chk(16'(i < 300), 16'h0001);
		chk(16'(doneSt & mask), 16'(expD));
		chk(16'(ops), 16'(expOps));
		chk(16'(busy), 16'h0000);
		if (expOps > 0) begin
			chk(16'(lastCmd), 16'(expCmd));
			chk(16'(opUnit), 16'(startUnit));
		end
		repeat (3) @(negedge clk);
		for (i = 0; i < 16; i++) far_u.mem[i] = '0;
		$display("test ended at %0t", $time);
	endtask
	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 16; i++) far_u.mem[i] = '0;
		repeat (12) @(negedge clk);
		reset = 1'b0;
		far_u.mem[0] = mk(8'h01, 5'h00, 3'h5, 16'h0003);
		run(24'h00_0000, 6'h20, 8'hc0, 8'hc0, 0, 8'h00);
		far_u.mem[0] = mk(8'h01, 5'h00, 3'h0, 16'h0000);
		run(24'h00_0000, 6'h20, 8'hc0, 8'hc0, 0, 8'h00);
		far_u.mem[0] = mk(8'h00, 5'h00, 3'h0, 16'h0005);
		run(24'h00_0000, 6'h20, 8'hc0, 8'hc0, 0, 8'h00);
		run(24'h00_1000, 6'h20, 8'hc0, 8'hc0, 0, 8'h00);
		cnt = 16'($random(seed)) | 16'h0001;
		far_u.mem[0] = mk(8'hf1, 5'h00, 3'h0, cnt);
		run(24'h00_0000, 6'h20, 8'he4, 8'h04, 1, 8'hf1);
		chk(lastCnt, cnt);
		chk(16'(opOutput), 16'h0001);
		far_u.mem[0] = mk(8'h01, 5'h08, 3'h0, 16'hffff);
		far_u.mem[1] = mk(8'h0c, 5'h00, 3'h0, 16'h0002);
		run(24'h00_0000, 6'h20, 8'he4, 8'h04, 2, 8'h0c);
		chk(16'(opBackward), 16'h0001);
		far_u.mem[0] = mk(8'h01, 5'h08, 3'h0, 16'h0001);
		far_u.mem[1] = mk(8'h0c, 5'h00, 3'h7, 16'h0002);
		far_u.mem[2] = mk(8'h02, 5'h00, 3'h0, 16'h0002);
		run(24'h00_0000, 6'h30, 8'he4, 8'h04, 2, 8'h02);
		far_u.mem[0] = mk(8'h01, 5'h08, 3'h0, 16'h0004);
		run(24'h00_0000, 6'h22, 8'he4, 8'h24, 1, 8'h01);
		far_u.mem[0] = mk(8'h01, 5'h0c, 3'h0, 16'h0004);
		far_u.mem[1] = mk(8'h02, 5'h04, 3'h0, 16'h0004);
		run(24'h00_0000, 6'h22, 8'he4, 8'h04, 2, 8'h02);
		far_u.mem[0] = mk(8'h03, 5'h08, 3'h0, 16'h0004);
		far_u.mem[1] = mk(8'h04, 5'h00, 3'h0, 16'h0004);
		run(24'h00_0000, 6'h23, 8'he4, 8'h04, 2, 8'h04);
		far_u.mem[0] = mk(8'h01, 5'h08, 3'h0, 16'h0004);
		run(24'h00_0000, 6'h20, 8'hc0, 8'h40, 1, 8'h01);
		far_u.mem[0] = mk(8'h08, 5'h00, 3'h7, 16'h0000);
		far_u.mem[8] = mk(8'h01, 5'h00, 3'h0, 16'h0004);
		run(24'h00_0000, 6'h20, 8'he4, 8'h04, 1, 8'h01);
		chk(16'(fetchAddr), 16'h0040);
		far_u.mem[0] = mk(8'h02, 5'h10, 3'h0, 16'h0004);
		far_u.mem[1] = mk(8'h00, 5'h03, 3'h0, 16'h0007);
		inj = 2'h1;
		run(24'h00_0000, 6'h20, 8'he4, 8'h04, 1, 8'h02);
		chk(16'(areas), 16'h0001);
		chk(opCount, 16'h0007);
		chk(16'(opSkip), 16'h0001);
		chk(16'(progs), 16'(channelEnabled));
		chk(16'(doneSt.progress), 16'(!channelEnabled));
		far_u.mem[0] = mk(8'h01, 5'h00, 3'h0, 16'h0004);
		inj = 2'h2;
		run(24'h00_0000, 6'h20, 8'he4, 8'h44, 1, 8'h01);
		chk(16'(terms), 16'h0001);
		inj = 2'h0;
		intPending = 1'b1;
		far_u.mem[0] = mk(8'h01, 5'h0c, 3'h0, 16'h0004);
		run(24'h00_0000, 6'h22, 8'he4, 8'h04, 1, 8'h01);
		intPending = 1'b0;
		give_verdict();
	end
endmodule
